// File: ead_decoder.sv
`timescale 1ns/1ps
`include "ead_defs.svh"
module ead_decoder import ead_pkg::*; (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic fetchValid,
    input wire logic [15:0] fetchWord,
    output logic fetchReady,
    input wire logic [31:0] opPc,
    input wire logic [1:0] hintSize,
    input wire logic hintJump,
    input wire logic [1:0] hintImmWords,
    input wire logic hintUseSrc,
    input wire logic hintUseDst,
    input wire logic [5:0] hintDstLoc,
    input wire logic hintStatus,
    input wire logic supervisor,
    input wire logic hostWrEn,
    input wire logic [4:0] hostWrIdx,
    input wire logic [31:0] hostWrData,
    output logic instrDone,
    output logic [2:0] instrLen,
    output logic [31:0] immOperand,
    output logic resValid,
    output ead_kind_e resKind,
    output logic [5:0] resLocator,
    output logic [4:0] resRegIdx,
    output logic [31:0] resAddr,
    output logic [31:0] resData,
    output logic resProgRef,
    output logic resAlignErr,
    output logic resIsDst
);
    // ----------------------------------------------------------------
    // State and datapath
    // ----------------------------------------------------------------
    ead_main_s r;
    ead_main_s n;
    logic accept;
    logic [2:0] curMode;
    logic [2:0] curReg;
    logic [4:0] rdIdxA;
    logic [4:0] rdIdxB;
    logic [31:0] rfRdA;
    logic [31:0] rfRdB;
    logic isStack;
    logic [31:0] locAddr;
    logic [31:0] locNewBase;
    logic locWb;
    logic wbEn;
    logic [31:0] immVal;

    assign accept = fetchValid && r.fetchReady;
    assign curMode = r.curLoc[5:3];
    assign curReg = r.curLoc[2:0];
    assign rdIdxA = ead_reg_index(curMode != `EAD_M_DREG, curReg, supervisor);
    assign rdIdxB = ead_reg_index(r.ext0[`EAD_X_ISADDR], r.ext0[`EAD_X_REG_HI:`EAD_X_REG_LO], supervisor);
    assign isStack = (curMode != `EAD_M_DREG) && (curReg == `EAD_SP_NUM);
    assign wbEn = (r.st == ST_CALC) && locWb;

    ead_regfile u_regs (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .rdIdxA(rdIdxA),
        .rdIdxB(rdIdxB),
        .rdDataA(rfRdA),
        .rdDataB(rfRdB),
        .hostWrEn(hostWrEn),
        .hostWrIdx(hostWrIdx),
        .hostWrData(hostWrData),
        .wbEn(wbEn),
        .wbIdx(rdIdxA),
        .wbData(locNewBase)
    );

    ead_locate u_locate (
        .loc(r.curLoc),
        .size(r.opSize),
        .isStack(isStack),
        .base(rfRdA),
        .indexReg(rfRdB),
        .ext0(r.ext0),
        .ext1(r.ext1),
        .pc(r.extPc),
        .addr(locAddr),
        .newBase(locNewBase),
        .wbNeed(locWb)
    );

    // Immediate operand held in the locator's own extension words
    always_comb
    begin
        case (r.opSize)
            `EAD_SZ_BYTE: immVal = {24'h000000, r.ext0[7:0]};
            `EAD_SZ_WORD: immVal = {16'h0000, r.ext0};
            default: immVal = {r.ext0, r.ext1};
        endcase
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [5:0] pickLoc;
        logic pickGo;
        logic [1:0] pickNeed;
        logic [2:0] srcLen;
        logic [2:0] dstLen;
        pickLoc = 6'h00;
        pickGo = 1'b0;
        pickNeed = 2'h0;
        srcLen = 3'h0;
        dstLen = 3'h0;
        n = r;
        n.resValid = 1'b0;
        n.instrDone = 1'b0;
        case (r.st)
            ST_OPWORD:
            begin
                if (accept)
                begin
                    n.wordPc = opPc + `EAD_WORD_BYTES;
                    n.opSize = hintSize;
                    n.isJump = hintJump;
                    n.immCount = hintImmWords;
                    n.useSrc = hintUseSrc;
                    n.useDst = hintUseDst;
                    n.allowStatus = hintStatus;
                    n.srcLoc = fetchWord[5:0];
                    n.dstLoc = hintDstLoc;
                    n.srcDone = 1'b0;
                    n.dstDone = 1'b0;
                    n.cnt = 2'h0;
                    n.immData = 32'h00000000;
                    // Length is fixed by the operation word and its hints alone
                    srcLen = hintUseSrc ? {1'b0, ead_ext_count(fetchWord[5:0], hintSize)} : 3'h0;
                    dstLen = hintUseDst ? {1'b0, ead_ext_count(hintDstLoc, hintSize)} : 3'h0;
                    n.instrLen = `EAD_MIN_LEN + {1'b0, hintImmWords} + srcLen + dstLen;
                    n.st = (hintImmWords != 2'h0) ? ST_IMM : ST_PICK;
                end
            end
            ST_IMM:
            begin
                if (accept)
                begin
                    n.immData = {r.immData[15:0], fetchWord};
                    n.wordPc = r.wordPc + `EAD_WORD_BYTES;
                    n.cnt = r.cnt + 2'h1;
                    if (r.cnt + 2'h1 == r.immCount)
                    begin
                        n.cnt = 2'h0;
                        n.st = ST_PICK;
                    end
                end
            end
            ST_PICK:
            begin
                // Source locator is always served before the destination
                if (r.useSrc && !r.srcDone)
                begin
                    pickLoc = r.srcLoc;
                    pickGo = 1'b1;
                    n.srcDone = 1'b1;
                    n.curIsDst = 1'b0;
                end
                else if (r.useDst && !r.dstDone)
                begin
                    pickLoc = r.dstLoc;
                    pickGo = 1'b1;
                    n.dstDone = 1'b1;
                    n.curIsDst = 1'b1;
                end
                if (pickGo)
                begin
                    pickNeed = ead_ext_count(pickLoc, r.opSize);
                    n.curLoc = pickLoc;
                    n.need = pickNeed;
                    n.cnt = 2'h0;
                    n.extPc = r.wordPc;
                    n.ext0 = 16'h0000;
                    n.ext1 = 16'h0000;
                    n.st = (pickNeed == 2'h0) ? ST_READ : ST_EXT;
                end
                else
                begin
                    n.instrDone = 1'b1;
                    n.st = ST_OPWORD;
                end
            end
            ST_EXT:
            begin
                if (accept)
                begin
                    if (r.cnt == 2'h0)
                        n.ext0 = fetchWord;
                    else
                        n.ext1 = fetchWord;
                    n.wordPc = r.wordPc + `EAD_WORD_BYTES;
                    n.cnt = r.cnt + 2'h1;
                    if (r.cnt + 2'h1 == r.need)
                        n.st = ST_READ;
                end
            end
            ST_READ:
            begin
                // Register file read data are registered, so wait one cycle
                n.st = ST_CALC;
            end
            ST_CALC:
            begin
                n.resValid = 1'b1;
                n.resLocator = r.curLoc;
                n.resRegIdx = rdIdxA;
                n.resIsDst = r.curIsDst;
                n.resAddr = locAddr;
                n.resData = rfRdA;
                n.resKind = EAD_KIND_MEM;
                n.resProgRef = r.isJump;
                case (curMode)
                    `EAD_M_DREG:
                    begin
                        n.resKind = EAD_KIND_DREG;
                        n.resProgRef = 1'b0;
                    end
                    `EAD_M_AREG:
                    begin
                        n.resKind = EAD_KIND_AREG;
                        n.resProgRef = 1'b0;
                    end
                    `EAD_M_POSTINC, `EAD_M_PREDEC: n.resProgRef = 1'b0;
                    `EAD_M_SPECIAL:
                    begin
                        case (curReg)
                            `EAD_S_ABSW, `EAD_S_ABSL: n.resProgRef = r.isJump;
                            `EAD_S_PCDISP, `EAD_S_PCINDEX: n.resProgRef = 1'b1;
                            `EAD_S_IMM:
                            begin
                                n.resProgRef = 1'b0;
                                n.resData = immVal;
                                n.resAddr = 32'h00000000;
                                if (r.allowStatus)
                                    n.resKind = (r.opSize == `EAD_SZ_BYTE) ? EAD_KIND_FLAGS : EAD_KIND_STATUS;
                                else
                                    n.resKind = EAD_KIND_IMM;
                            end
                            default:
                            begin
                                n.resKind = EAD_KIND_BAD;
                                n.resProgRef = 1'b0;
                                n.resAddr = 32'h00000000;
                            end
                        endcase
                    end
                    default: n.resKind = EAD_KIND_MEM;
                endcase
                // Odd address for word or long data is flagged, not fixed up
                n.resAlignErr = (n.resKind == EAD_KIND_MEM) && (r.opSize != `EAD_SZ_BYTE) && n.resAddr[0];
                n.st = ST_PICK;
            end
            default: n.st = ST_OPWORD;
        endcase
        n.fetchReady = (n.st == ST_OPWORD) || (n.st == ST_IMM) || (n.st == ST_EXT);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            r <= '0;
        else
            r <= n;
    end

    assign fetchReady = r.fetchReady;
    assign instrDone = r.instrDone;
    assign instrLen = r.instrLen;
    assign immOperand = r.immData;
    assign resValid = r.resValid;
    assign resKind = r.resKind;
    assign resLocator = r.resLocator;
    assign resRegIdx = r.resRegIdx;
    assign resAddr = r.resAddr;
    assign resData = r.resData;
    assign resProgRef = r.resProgRef;
    assign resAlignErr = r.resAlignErr;
    assign resIsDst = r.resIsDst;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    chk_len_bound: assert property (
        instrDone |-> (instrLen >= `EAD_MIN_LEN) && (instrLen <= `EAD_MAX_LEN))
        else $error("instruction length outside one to five words");

    chk_register_direct: assert property (
        resValid && resLocator[5:3] == `EAD_M_DREG |-> resKind == EAD_KIND_DREG && resRegIdx == {2'h0, resLocator[2:0]})
        else $error("data register direct mis-decoded");

    chk_field_split: assert property (
        resValid && resKind == EAD_KIND_AREG |-> resLocator[5:3] == `EAD_M_AREG && resRegIdx >= `EAD_AREG_BASE)
        else $error("address register direct mode or index wrong");

    chk_postinc_step: assert property (
        wbEn && curMode == `EAD_M_POSTINC |-> locNewBase == rfRdA + ead_step(r.opSize, isStack) && locAddr == rfRdA)
        else $error("postincrement step or address wrong");

    chk_predec_addr: assert property (
        wbEn && curMode == `EAD_M_PREDEC |=> resValid && resAddr == $past(rfRdA) - ead_step($past(r.opSize), $past(isStack)))
        else $error("predecrement address wrong");

    chk_stack_byte: assert property (
        wbEn && isStack && r.opSize == `EAD_SZ_BYTE |-> (locNewBase == rfRdA + 32'h2) || (locNewBase == rfRdA - 32'h2))
        else $error("stack pointer byte step not two");

    chk_abs_long: assert property (
        resValid && resLocator == {`EAD_M_SPECIAL, `EAD_S_ABSL} |-> resAddr == {r.ext0, r.ext1})
        else $error("absolute long halves in wrong order");

    chk_pc_program: assert property (
        resValid && resLocator[5:3] == `EAD_M_SPECIAL && resLocator[2:1] == 2'h1 |-> resProgRef)
        else $error("pc relative access not a program reference");

    chk_data_class: assert property (
        resValid && (resLocator[5:3] == `EAD_M_POSTINC || resLocator[5:3] == `EAD_M_PREDEC) |-> !resProgRef)
        else $error("stepping modes must be data references");

    chk_align_flag: assert property (
        resValid |-> resAlignErr == (resKind == EAD_KIND_MEM && r.opSize != `EAD_SZ_BYTE && resAddr[0]))
        else $error("alignment flag wrong");

    chk_ext_order: assert property (
        r.st == ST_IMM || r.st == ST_EXT |-> (r.st == ST_IMM) ? (!r.srcDone && !r.dstDone)
            : (r.curIsDst ? (r.dstDone && (r.srcDone || !r.useSrc)) : (r.srcDone && !r.dstDone)))
        else $error("extension words taken out of order");

    chk_ready_stop: assert property (
        accept && r.st == ST_EXT && r.cnt + 2'h1 == r.need |=> !fetchReady ##1 !fetchReady)
        else $error("fetch stream still accepted after last extension");
endmodule : ead_decoder

// File: ead_defs.svh
`ifndef EAD_DEFS_SVH
`define EAD_DEFS_SVH

// ----------------------------------------------------------------
// Register file layout
// ----------------------------------------------------------------
`define EAD_NREGS 17
`define EAD_AREG_BASE 5'h08
`define EAD_USP_IDX 5'h0F
`define EAD_SSP_IDX 5'h10
`define EAD_SP_NUM 3'h7

// ----------------------------------------------------------------
// Locator mode codes and special-group register codes
// ----------------------------------------------------------------
`define EAD_M_DREG 3'h0
`define EAD_M_AREG 3'h1
`define EAD_M_IND 3'h2
`define EAD_M_POSTINC 3'h3
`define EAD_M_PREDEC 3'h4
`define EAD_M_DISP 3'h5
`define EAD_M_INDEX 3'h6
`define EAD_M_SPECIAL 3'h7
`define EAD_S_ABSW 3'h0
`define EAD_S_ABSL 3'h1
`define EAD_S_PCDISP 3'h2
`define EAD_S_PCINDEX 3'h3
`define EAD_S_IMM 3'h4

// ----------------------------------------------------------------
// Operand sizes, extension word fields, lengths
// ----------------------------------------------------------------
`define EAD_SZ_BYTE 2'h0
`define EAD_SZ_WORD 2'h1
`define EAD_SZ_LONG 2'h2
`define EAD_X_ISADDR 15
`define EAD_X_REG_HI 14
`define EAD_X_REG_LO 12
`define EAD_X_LONG 11
`define EAD_MIN_LEN 3'h1
`define EAD_MAX_LEN 3'h5
`define EAD_WORD_BYTES 32'h00000002

`endif

// File: ead_fetch_model.sv
`timescale 1ns/1ps
module ead_fetch_model (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic fetchReady,
    output logic fetchValid,
    output logic [15:0] fetchWord
);
    logic [15:0] q[$];
    logic tk;
    task automatic push(input logic [15:0] w);
        q.push_back(w);
    endtask : push
    initial
    begin
        fetchValid = 1'b0;
        fetchWord = 16'hFFFF;
    end
    // Words leave strictly in stream order; idle bus shows inverted junk
    always @(posedge sys_clk)
    begin
        tk = fetchValid && fetchReady && rstn;
        #2;
        if (tk)
            void'(q.pop_front());
        fetchValid = q.size() != 0;
        fetchWord = fetchValid ? q[0] : ~fetchWord;
    end
endmodule : ead_fetch_model

// File: ead_locate.sv
`timescale 1ns/1ps
`include "ead_defs.svh"
module ead_locate import ead_pkg::*; (
    input wire logic [5:0] loc,
    input wire logic [1:0] size,
    input wire logic isStack,
    input wire logic [31:0] base,
    input wire logic [31:0] indexReg,
    input wire logic [15:0] ext0,
    input wire logic [15:0] ext1,
    input wire logic [31:0] pc,
    output logic [31:0] addr,
    output logic [31:0] newBase,
    output logic wbNeed
);
    logic [31:0] indexVal;
    logic [31:0] step;

    always_comb
    begin
        indexVal = ext0[`EAD_X_LONG] ? indexReg : ead_sext16(indexReg[15:0]);
        step = ead_step(size, isStack);
        addr = base;
        newBase = base;
        wbNeed = 1'b0;
        case (loc[5:3])
            `EAD_M_POSTINC:
            begin
                newBase = base + step;
                wbNeed = 1'b1;
            end
            `EAD_M_PREDEC:
            begin
                addr = base - step;
                newBase = base - step;
                wbNeed = 1'b1;
            end
            `EAD_M_DISP: addr = base + ead_sext16(ext0);
            `EAD_M_INDEX: addr = base + ead_sext8(ext0[7:0]) + indexVal;
            `EAD_M_SPECIAL:
            begin
                case (loc[2:0])
                    `EAD_S_ABSW: addr = ead_sext16(ext0);
                    `EAD_S_ABSL: addr = {ext0, ext1};
                    `EAD_S_PCDISP: addr = pc + ead_sext16(ext0);
                    `EAD_S_PCINDEX: addr = pc + ead_sext8(ext0[7:0]) + indexVal;
                    default: addr = 32'h00000000;
                endcase
            end
            default: addr = base;
        endcase
    end
endmodule : ead_locate

// File: ead_pkg.sv
package ead_pkg;
`include "ead_defs.svh"

    typedef enum logic [2:0] {ST_OPWORD, ST_IMM, ST_PICK, ST_EXT, ST_READ, ST_CALC} ead_state_e;

    typedef enum logic [2:0] {
        EAD_KIND_DREG, EAD_KIND_AREG, EAD_KIND_MEM, EAD_KIND_IMM,
        EAD_KIND_STATUS, EAD_KIND_FLAGS, EAD_KIND_BAD
    } ead_kind_e;

    typedef struct packed {
        logic [`EAD_NREGS-1:0][31:0] regs;
        logic [31:0] rdA;
        logic [31:0] rdB;
    } ead_rf_s;

    typedef struct packed {
        ead_state_e st;
        logic fetchReady;
        logic [31:0] wordPc;
        logic [1:0] opSize;
        logic isJump;
        logic [1:0] immCount;
        logic useSrc;
        logic useDst;
        logic allowStatus;
        logic [5:0] srcLoc;
        logic [5:0] dstLoc;
        logic srcDone;
        logic dstDone;
        logic [5:0] curLoc;
        logic curIsDst;
        logic [1:0] cnt;
        logic [1:0] need;
        logic [15:0] ext0;
        logic [15:0] ext1;
        logic [31:0] extPc;
        logic [31:0] immData;
        logic [2:0] instrLen;
        logic instrDone;
        logic resValid;
        ead_kind_e resKind;
        logic [5:0] resLocator;
        logic [4:0] resRegIdx;
        logic [31:0] resAddr;
        logic [31:0] resData;
        logic resProgRef;
        logic resAlignErr;
        logic resIsDst;
    } ead_main_s;

    function automatic logic [31:0] ead_sext16(input logic [15:0] v);
        ead_sext16 = {{16{v[15]}}, v};
    endfunction : ead_sext16

    function automatic logic [31:0] ead_sext8(input logic [7:0] v);
        ead_sext8 = {{24{v[7]}}, v};
    endfunction : ead_sext8

    // Address register seven resolves to one of two physical pointers
    function automatic logic [4:0] ead_reg_index(input logic isAddr, input logic [2:0] num, input logic sup);
        if (!isAddr)
            ead_reg_index = {2'h0, num};
        else if (num != `EAD_SP_NUM)
            ead_reg_index = `EAD_AREG_BASE + {2'h0, num};
        else
            ead_reg_index = sup ? `EAD_SSP_IDX : `EAD_USP_IDX;
    endfunction : ead_reg_index

    function automatic logic [1:0] ead_ext_count(input logic [5:0] loc, input logic [1:0] size);
        ead_ext_count = 2'h0;
        if (loc[5:3] == `EAD_M_DISP || loc[5:3] == `EAD_M_INDEX)
            ead_ext_count = 2'h1;
        else if (loc[5:3] == `EAD_M_SPECIAL)
        begin
            case (loc[2:0])
                `EAD_S_ABSW, `EAD_S_PCDISP, `EAD_S_PCINDEX: ead_ext_count = 2'h1;
                `EAD_S_ABSL: ead_ext_count = 2'h2;
                `EAD_S_IMM: ead_ext_count = (size == `EAD_SZ_LONG) ? 2'h2 : 2'h1;
                default: ead_ext_count = 2'h0;
            endcase
        end
    endfunction : ead_ext_count

    function automatic logic [31:0] ead_step(input logic [1:0] size, input logic isStack);
        case (size)
            `EAD_SZ_BYTE: ead_step = isStack ? 32'h00000002 : 32'h00000001;
            `EAD_SZ_WORD: ead_step = 32'h00000002;
            default: ead_step = 32'h00000004;
        endcase
    endfunction : ead_step
endpackage : ead_pkg

// File: ead_regfile.sv
`timescale 1ns/1ps
`include "ead_defs.svh"
module ead_regfile import ead_pkg::*; (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [4:0] rdIdxA,
    input wire logic [4:0] rdIdxB,
    output logic [31:0] rdDataA,
    output logic [31:0] rdDataB,
    input wire logic hostWrEn,
    input wire logic [4:0] hostWrIdx,
    input wire logic [31:0] hostWrData,
    input wire logic wbEn,
    input wire logic [4:0] wbIdx,
    input wire logic [31:0] wbData
);
    ead_rf_s r;
    ead_rf_s n;

    always_comb
    begin
        n = r;
        n.rdA = (rdIdxA < 5'(`EAD_NREGS)) ? r.regs[rdIdxA] : 32'h00000000;
        n.rdB = (rdIdxB < 5'(`EAD_NREGS)) ? r.regs[rdIdxB] : 32'h00000000;
        if (hostWrEn && hostWrIdx < 5'(`EAD_NREGS))
            n.regs[hostWrIdx] = hostWrData;
        // Decoder writeback wins over a host write to the same register
        if (wbEn && wbIdx < 5'(`EAD_NREGS))
            n.regs[wbIdx] = wbData;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            r <= '0;
        else
            r <= n;
    end

    assign rdDataA = r.rdA;
    assign rdDataB = r.rdB;
endmodule : ead_regfile

// File: effective_address_decoder_tb.sv
`timescale 1ns/1ps
`include "ead_defs.svh"
module effective_address_decoder_tb import ead_pkg::*;;
    logic sys_clk = 0, rstn = 0, fetchValid, fetchReady, hintJump = 0, hintUseSrc = 1, hintUseDst = 0;
    logic hintStatus = 0, supervisor = 1, hostWrEn = 0, instrDone, resValid, resProgRef, resAlignErr, resIsDst;
    logic [15:0] fetchWord;
    logic [31:0] opPc = 0, hostWrData = 0, immOperand, resAddr, resData;
    logic [1:0] hintSize = 0, hintImmWords = 0;
    logic [5:0] hintDstLoc = 0, resLocator;
    logic [4:0] hostWrIdx = 0, resRegIdx;
    logic [2:0] instrLen;
    ead_kind_e resKind;
    int num_errors = 0, checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    ead_fetch_model u_ead_fetch_model (.sys_clk(sys_clk), .rstn(rstn), .fetchReady(fetchReady),
        .fetchValid(fetchValid), .fetchWord(fetchWord));
    ead_decoder u_ead_decoder (.sys_clk(sys_clk), .rstn(rstn), .fetchValid(fetchValid), .fetchWord(fetchWord),
        .fetchReady(fetchReady), .opPc(opPc), .hintSize(hintSize), .hintJump(hintJump),
        .hintImmWords(hintImmWords), .hintUseSrc(hintUseSrc), .hintUseDst(hintUseDst), .hintDstLoc(hintDstLoc),
        .hintStatus(hintStatus), .supervisor(supervisor), .hostWrEn(hostWrEn), .hostWrIdx(hostWrIdx),
        .hostWrData(hostWrData), .instrDone(instrDone), .instrLen(instrLen), .immOperand(immOperand),
        .resValid(resValid), .resKind(resKind), .resLocator(resLocator), .resRegIdx(resRegIdx),
        .resAddr(resAddr), .resData(resData), .resProgRef(resProgRef), .resAlignErr(resAlignErr),
        .resIsDst(resIsDst));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [4:0] idx, input logic [31:0] d);
        @(posedge sys_clk);
        #2 hostWrEn = 1;
        hostWrIdx = idx;
        hostWrData = d;
        @(posedge sys_clk);
        #2 hostWrEn = 0;
    endtask : wr
    // Queue one instruction's words with its size, immediate count and address
    task automatic issue(input logic [79:0] ws, input int n, input logic [1:0] sz, input logic [1:0] imm,
        input logic [31:0] pc);
        int k;
        @(posedge sys_clk);
        #2 hintSize = sz;
        hintImmWords = imm;
        opPc = pc;
        for (k = 0; k < n; k++)
            u_ead_fetch_model.push(ws[79-16*k -: 16]);
    endtask : issue
    // Step past the current cycle so a pulse already seen is not taken twice
    task automatic wait_pulse(input bit done);
        int k;
        @(posedge sys_clk);
        #1 k = 0;
        while ((done ? instrDone : resValid) !== 1'b1 && k < 40)
        begin
            @(posedge sys_clk);
            #1 k++;
        end
        check("pulse", done ? instrDone : resValid, 1);
    endtask : wait_pulse
    task automatic run(input logic [79:0] ws, input int n, input logic [1:0] sz, input logic [1:0] imm,
        input logic [31:0] pc);
        issue(ws, n, sz, imm, pc);
        wait_pulse(0);
        wait_pulse(1);
    endtask : run
    task automatic hints(input logic d, input logic [5:0] dl, input logic j, input logic s, input logic sv);
        @(posedge sys_clk);
        #2 hintUseDst = d;
        hintDstLoc = dl;
        hintJump = j;
        hintStatus = s;
        supervisor = sv;
    endtask : hints
    task automatic t_disp();
        wr(5'h09, 32'h00001000);
        run({16'h0029, 16'hFFFE, 48'h0}, 2, `EAD_SZ_WORD, 0, 0);
        check("addr", resAddr, 32'h00000FFE);
        check("kind", 32'(resKind), 32'(EAD_KIND_MEM));
        check("prog", resProgRef, 0);
        check("len", instrLen, 2);
        check("align", resAlignErr, 0);
    endtask : t_disp
    task automatic t_predec_sp();
        wr(5'h10, 32'h00002000);
        run({16'h0027, 64'h0}, 1, `EAD_SZ_BYTE, 0, 0);
        check("addr", resAddr, 32'h00001FFE);
        check("reg", resRegIdx, 5'h10);
        run({16'h0027, 64'h0}, 1, `EAD_SZ_BYTE, 0, 0);
        check("addr2", resAddr, 32'h00001FFC);
    endtask : t_predec_sp
    task automatic t_imm_abs();
        run({16'h0039, 16'h1234, 16'h5678, 16'h0001, 16'h0002}, 5, `EAD_SZ_LONG, 2, 0);
        check("imm", immOperand, 32'h12345678);
        check("addr", resAddr, 32'h00010002);
        check("len", instrLen, 5);
    endtask : t_imm_abs
    task automatic t_pcdisp();
        run({16'h003A, 16'h0010, 48'h0}, 2, `EAD_SZ_WORD, 0, 32'h00000100);
        check("addr", resAddr, 32'h00000112);
        check("prog", resProgRef, 1);
    endtask : t_pcdisp
    task automatic t_two_loc();
        wr(5'h03, 32'h11223344);
        wr(5'h0A, 32'h00003001);
        hints(1, 6'h0A, 1, 0, 1);
        issue({16'h0003, 64'h0}, 1, `EAD_SZ_WORD, 0, 0);
        wait_pulse(0);
        check("kind", 32'(resKind), 32'(EAD_KIND_DREG));
        check("data", resData, 32'h11223344);
        check("dst", resIsDst, 0);
        wait_pulse(0);
        check("kind", 32'(resKind), 32'(EAD_KIND_AREG));
        check("reg", resRegIdx, 5'h0A);
        check("prog", resProgRef, 0);
        check("dst", resIsDst, 1);
        wait_pulse(1);
        hints(0, 6'h00, 1, 0, 1);
        run({16'h0012, 64'h0}, 1, `EAD_SZ_WORD, 0, 0);
        check("addr", resAddr, 32'h00003001);
        check("prog", resProgRef, 1);
        check("align", resAlignErr, 1);
    endtask : t_two_loc
    task automatic t_index_usp();
        hints(0, 6'h00, 0, 0, 0);
        run({16'h0031, 16'h30FC, 48'h0}, 2, `EAD_SZ_WORD, 0, 0);
        check("addr", resAddr, 32'h00004340);
        run({16'h0031, 16'h38FC, 48'h0}, 2, `EAD_SZ_WORD, 0, 0);
        check("addr", resAddr, 32'h11224340);
        run({16'h003B, 16'h30FC, 48'h0}, 2, `EAD_SZ_WORD, 0, 32'h00000200);
        check("addr", resAddr, 32'h00003542);
        check("prog", resProgRef, 1);
        wr(5'h0F, 32'h00000500);
        run({16'h001F, 64'h0}, 1, `EAD_SZ_BYTE, 0, 0);
        check("reg", resRegIdx, 5'h0F);
        run({16'h0017, 64'h0}, 1, `EAD_SZ_BYTE, 0, 0);
        check("addr", resAddr, 32'h00000502);
    endtask : t_index_usp
    task automatic t_imm_kinds();
        hints(0, 6'h00, 0, 1, 1);
        run({16'h003C, 16'h12A5, 48'h0}, 2, `EAD_SZ_BYTE, 0, 0);
        check("kind", 32'(resKind), 32'(EAD_KIND_FLAGS));
        check("data", resData, 32'h000000A5);
        hints(0, 6'h00, 0, 0, 1);
        run({16'h003C, 16'h1234, 48'h0}, 2, `EAD_SZ_WORD, 0, 0);
        check("kind", 32'(resKind), 32'(EAD_KIND_IMM));
        run({16'h0038, 16'h8000, 48'h0}, 2, `EAD_SZ_WORD, 0, 0);
        check("addr", resAddr, 32'hFFFF8000);
    endtask : t_imm_kinds
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge sys_clk);
        #2 rstn = 1;
        t_disp();
        t_predec_sp();
        t_imm_abs();
        t_pcdisp();
        t_two_loc();
        t_index_usp();
        t_imm_kinds();
        finish_test();
    end
    initial
    begin
        #100000;
        num_errors++;
        finish_test();
    end
endmodule : effective_address_decoder_tb
